/* File: rescmd_pkg.sv */
// Behaviour
// [R1] Each channel's 10-bit setting decodes to one of 1024 wiper taps.
// [R2] Bottom-terminal switch always closed; exactly one tap switch closed at a time.
// [R3] Setting zero selects the first connection at the bottom terminal.
// [R4] Each increment of the setting moves one tap up; 1023 is the last tap.
// [R5] Each frame shifts out the 24-bit word received in the previous frame.
// [R6] Code B with address 0 or 1 loads the data field into that channel.
// [R7] Code E increments the addressed channel by one and ignores the data field.
// [R8] Code 2 saves the addressed channel setting into its nonvolatile word.
// [R9] Code 1 restores the addressed channel from its nonvolatile word.
// [R10] Code 8 restores both channels from their nonvolatile words, any address.
// [R11] Code C doubles the addressed channel by a left shift.
// [R12] A left shift from mid-scale or above saturates at full scale.
// [R13] Code 3 stores the 16-bit data into one of thirteen user slots.
// [R14] Code 9 makes the next frame return command, address and user slot contents.
// [R15] Code A makes the next frame return command, address and channel setting.
// [R16] Code 0 does nothing and returns the device to idle low power.
// [R17] Write-protect held low blocks every change to nonvolatile words.
// [R18] Settings reload from nonvolatile words at power-on, preset strobe or restore.
// [R19] A frame is 4-bit command, 4-bit address, 16-bit data.
// [R20] Frames travel most significant bit first.
// [R21] Serial port works as slave in clock modes 1/1 and 0/0.
// [R22] The master never addresses nonvolatile location 15.
// [R23] Only frames of exactly 24 bits execute, when chip select rises; a select with no clock reruns the previous frame if it had 24 bits.
package rescmd_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam int RES_W = 10;
    localparam int DATA_W = 16;
    localparam int NV_WORDS = 16;
    localparam logic [4:0] FRAME_LEN = 5'h18;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] CNT_MAX = 5'h1f;
    localparam int CMD_LSB = 20;
    localparam int ADDR_LSB = 16;
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_RESTORE = 4'h1;
    localparam logic [3:0] CMD_SAVE = 4'h2;
    localparam logic [3:0] CMD_USER_WR = 4'h3;
    localparam logic [3:0] CMD_RESTORE_ALL = 4'h8;
    localparam logic [3:0] CMD_USER_RD = 4'h9;
    localparam logic [3:0] CMD_WIPER_RD = 4'ha;
    localparam logic [3:0] CMD_LOAD = 4'hb;
    localparam logic [3:0] CMD_SHL = 4'hc;
    localparam logic [3:0] CMD_INC = 4'he;
    localparam logic [3:0] ADDR_USER_LO = 4'h2;
    localparam logic [3:0] ADDR_USER_HI = 4'he;
    localparam logic [9:0] RES_FULL = 10'h3ff;
    localparam logic [9:0] RES_MID = 10'h200;
    localparam logic [9:0] RES_RST = 10'h000;
    localparam logic [15:0] NV_RST = 16'h0000;
    localparam logic [23:0] ECHO_RST = 24'h000000;
    typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_READ} state_t;
endpackage

/* File: tap_decoder.sv */
`timescale 1ns/1ps
module tap_decoder #(
    parameter int BITS = rescmd_pkg::RES_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [BITS-1:0] code,
    output logic [2**BITS-1:0] tap,
    output logic bottom_sw
);
    localparam logic [2**BITS-1:0] FIRST_TAP = {{(2**BITS-1){1'b0}}, 1'b1};

    always_ff @(posedge mclk) begin
        if (rst) begin
            tap <= FIRST_TAP; // R3
        end else begin
            tap <= FIRST_TAP << code; // R1 R4
        end
    end

    always_ff @(posedge mclk) begin
        bottom_sw <= 1'b1; // R2
    end

    one_tap_a: assert property (@(posedge mclk) disable iff (rst) $onehot(tap)) // R2
        else $error("tap selection is not exactly one switch");
    tap_pos_a: assert property (@(posedge mclk) disable iff (rst) // R1
        !$past(rst) |-> tap == (FIRST_TAP << $past(code)))
        else $error("closed tap does not follow the setting");
endmodule // tap_decoder

/* File: serial_link.sv */
`timescale 1ns/1ps
module serial_link (
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic [23:0] echo_word,
    output logic [23:0] rx_word,
    output logic [4:0] rx_count,
    output logic serial_out_oe
);
    logic active_r;
    logic started_r;
    logic out_bit_r;
    logic [4:0] idx;

    // The select releases these flags directly, since no clock edge follows a frame.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            active_r <= 1'b0;
        end else begin
            active_r <= 1'b1;
        end
    end

    always_ff @(posedge sclk) begin
        rx_word <= {rx_word[22:0], serial_in}; // R20 R21
    end

    // Saturating count: anything beyond the frame length stays invalid.
    always_ff @(posedge sclk) begin
        if (!active_r) begin
            rx_count <= 5'h01;
        end else if (rx_count != rescmd_pkg::CNT_MAX) begin
            rx_count <= rx_count + 5'h01;
        end
    end

    assign idx = active_r ? rx_count : 5'h00;

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            started_r <= 1'b0;
        end else begin
            started_r <= 1'b1;
        end
    end

    always_ff @(negedge sclk) begin
        if (idx < rescmd_pkg::FRAME_LEN) begin
            out_bit_r <= echo_word[rescmd_pkg::FRAME_LAST - idx]; // R5
        end else begin
            out_bit_r <= 1'b1;
        end
    end

    // Before the first falling edge the top bit must already be valid for mode 0/0.
    assign serial_out_oe = !cs_n && !(started_r ? out_bit_r : echo_word[23]); // R21
endmodule // serial_link

/* File: dual_resistor_serial_command_core.sv */
`timescale 1ns/1ps
module dual_resistor_serial_command_core (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic wp_n,
    input wire logic preset_strobe_n,
    output logic serial_out,
    output logic serial_out_oe,
    output logic [1023:0] tap_sel_ch1,
    output logic [1023:0] tap_sel_ch2,
    output logic [1:0] bottom_terminal_switch,
    output logic [9:0] resistor_setting_ch1,
    output logic [9:0] resistor_setting_ch2,
    output logic read_mode
);
    ////////////////////////////////////////////////////////////////////////
    logic [23:0] rx_word;
    logic [4:0] rx_count;
    logic [23:0] echo_r;
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_s3_r;
    logic wp_s1_r;
    logic wp_s2_r;
    logic pr_s1_r;
    logic pr_s2_r;
    logic pr_s3_r;
    logic [9:0] res_r [0:1];
    logic [15:0] nv_r [0:rescmd_pkg::NV_WORDS-1];
    rescmd_pkg::state_t state_r;
    rescmd_pkg::state_t state_nxt;
    logic read_mode_r;
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
    logic [7:0] hdr;
    logic ch;
    logic ch_ok;
    logic user_ok;
    logic wp_ok;
    logic frame_end;
    logic frame_go;
    logic preset_go;
    logic [9:0] sel_res;
    logic [15:0] nv_sel;
    logic [9:0] nv_ch1;
    logic [9:0] nv_ch2;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    function automatic logic [9:0] shl_sat(input logic [9:0] v);
        return (v >= rescmd_pkg::RES_MID) ? rescmd_pkg::RES_FULL : {v[8:0], 1'b0};
    endfunction

    function automatic logic [9:0] inc_sat(input logic [9:0] v);
        return (v == rescmd_pkg::RES_FULL) ? v : v + 10'h001;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    serial_link u_link (
        .sclk(sclk),
        .cs_n(cs_n),
        .serial_in(serial_in),
        .echo_word(echo_r),
        .rx_word(rx_word),
        .rx_count(rx_count),
        .serial_out_oe(serial_out_oe)
    );

    // The pin only ever pulls low; the enable carries the data.
    assign serial_out = 1'b0;

    // Select, write-protect and preset pins are brought into the mclk domain before the mclk logic looks at them.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
        end else begin
            cs_s1_r <= cs_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wp_s1_r <= 1'b1;
            wp_s2_r <= 1'b1;
        end else begin
            wp_s1_r <= wp_n;
            wp_s2_r <= wp_s1_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pr_s1_r <= 1'b1;
            pr_s2_r <= 1'b1;
            pr_s3_r <= 1'b1;
        end else begin
            pr_s1_r <= preset_strobe_n;
            pr_s2_r <= pr_s1_r;
            pr_s3_r <= pr_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The received word and count are still while select is high, so they are
    // read as settled values two mclk cycles after the rising select.
    assign cmd = rx_word[23:rescmd_pkg::CMD_LSB]; // R19
    assign addr = rx_word[rescmd_pkg::CMD_LSB-1:rescmd_pkg::ADDR_LSB];
    assign data = rx_word[rescmd_pkg::DATA_W-1:0];
    assign hdr = rx_word[23:rescmd_pkg::ADDR_LSB];
    assign ch = addr[0];
    assign ch_ok = (addr[3:1] == 3'h0);
    assign user_ok = addr >= rescmd_pkg::ADDR_USER_LO && addr <= rescmd_pkg::ADDR_USER_HI; // R22
    assign wp_ok = wp_s2_r;
    assign frame_end = cs_s2_r && !cs_s3_r;
    assign frame_go = frame_end && rx_count == rescmd_pkg::FRAME_LEN; // R23
    assign preset_go = !pr_s2_r && pr_s3_r;
    assign sel_res = res_r[ch];
    assign nv_sel = nv_r[addr];
    assign nv_ch1 = nv_r[0][9:0];
    assign nv_ch2 = nv_r[1][9:0];

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (rst) begin
            res_r[0] <= rescmd_pkg::RES_RST;
            res_r[1] <= rescmd_pkg::RES_RST;
        end else if (state_r == rescmd_pkg::ST_BOOT || preset_go) begin
            res_r[0] <= nv_ch1; // R18
            res_r[1] <= nv_ch2;
        end else if (frame_go && ch_ok) begin
            unique case (cmd)
                rescmd_pkg::CMD_LOAD: res_r[ch] <= data[9:0]; // R6
                rescmd_pkg::CMD_INC: res_r[ch] <= inc_sat(sel_res); // R7
                rescmd_pkg::CMD_SHL: res_r[ch] <= shl_sat(sel_res); // R11 R12
                rescmd_pkg::CMD_RESTORE: res_r[ch] <= nv_r[{3'h0, ch}][9:0]; // R9
                rescmd_pkg::CMD_RESTORE_ALL: begin
                    res_r[0] <= nv_ch1; // R10
                    res_r[1] <= nv_ch2;
                end
                default: begin
                end
            endcase
        end else if (frame_go && cmd == rescmd_pkg::CMD_RESTORE_ALL) begin
            res_r[0] <= nv_ch1; // R10
            res_r[1] <= nv_ch2;
        end
    end

    assign resistor_setting_ch1 = res_r[0];
    assign resistor_setting_ch2 = res_r[1];

    // A reset stands for power-on of a blank part, so the store starts cleared.
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < rescmd_pkg::NV_WORDS; i++) begin
                nv_r[i] <= rescmd_pkg::NV_RST;
            end
        end else if (frame_go && wp_ok) begin // R17
            if (cmd == rescmd_pkg::CMD_SAVE && ch_ok) begin
                nv_r[{3'h0, ch}] <= {6'h00, sel_res}; // R8
            end else if (cmd == rescmd_pkg::CMD_USER_WR && user_ok) begin
                nv_r[addr] <= data; // R13
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (rst) begin
            echo_r <= rescmd_pkg::ECHO_RST;
        end else if (frame_go) begin
            if (cmd == rescmd_pkg::CMD_USER_RD) begin
                echo_r <= {hdr, nv_sel}; // R14
            end else if (cmd == rescmd_pkg::CMD_WIPER_RD && ch_ok) begin
                echo_r <= {hdr, 6'h00, sel_res}; // R15
            end else begin
                echo_r <= rx_word; // R5
            end
        end
    end

    always_comb begin
        state_nxt = state_r;
        if (state_r == rescmd_pkg::ST_BOOT) begin
            state_nxt = rescmd_pkg::ST_IDLE;
        end else if (frame_go) begin
            unique case (cmd)
                rescmd_pkg::CMD_NOP: state_nxt = rescmd_pkg::ST_IDLE; // R16
                rescmd_pkg::CMD_RESTORE,
                rescmd_pkg::CMD_RESTORE_ALL,
                rescmd_pkg::CMD_USER_RD,
                rescmd_pkg::CMD_WIPER_RD: state_nxt = rescmd_pkg::ST_READ;
                default: state_nxt = state_r;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= rescmd_pkg::ST_BOOT;
            read_mode_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            read_mode_r <= state_nxt == rescmd_pkg::ST_READ;
        end
    end

    assign read_mode = read_mode_r;

    ////////////////////////////////////////////////////////////////////////
    tap_decoder u_tap1 (
        .mclk(mclk),
        .rst(rst),
        .code(res_r[0]),
        .tap(tap_sel_ch1),
        .bottom_sw(bottom_terminal_switch[0])
    );

    tap_decoder u_tap2 (
        .mclk(mclk),
        .rst(rst),
        .code(res_r[1]),
        .tap(tap_sel_ch2),
        .bottom_sw(bottom_terminal_switch[1])
    );

    ////////////////////////////////////////////////////////////////////////
    load_wiper_a: assert property ( // R6
        frame_go && cmd == rescmd_pkg::CMD_LOAD && ch_ok && !preset_go
        |=> res_r[$past(ch)] == $past(data[9:0]))
        else $error("load did not set the addressed channel");
    step_up_a: assert property ( // R7
        frame_go && cmd == rescmd_pkg::CMD_INC && ch_ok && !preset_go
        && sel_res != rescmd_pkg::RES_FULL
        |=> res_r[$past(ch)] == $past(sel_res) + 10'h001)
        else $error("increment did not add exactly one");
    shift_double_a: assert property ( // R11
        frame_go && cmd == rescmd_pkg::CMD_SHL && ch_ok && !preset_go
        && sel_res < rescmd_pkg::RES_MID
        |=> res_r[$past(ch)] == 10'($past(sel_res) << 1))
        else $error("left shift did not double the setting");
    shift_sat_a: assert property ( // R12
        frame_go && cmd == rescmd_pkg::CMD_SHL && ch_ok && !preset_go
        && sel_res >= rescmd_pkg::RES_MID
        |=> res_r[$past(ch)] == rescmd_pkg::RES_FULL)
        else $error("left shift from mid-scale did not saturate");
    save_word_a: assert property ( // R8
        frame_go && cmd == rescmd_pkg::CMD_SAVE && ch_ok && wp_ok
        |=> nv_r[{3'h0, $past(ch)}] == {6'h00, $past(sel_res)})
        else $error("save did not copy the setting");
    user_store_a: assert property ( // R13
        frame_go && cmd == rescmd_pkg::CMD_USER_WR && user_ok && wp_ok
        |=> nv_r[$past(addr)] == $past(data))
        else $error("user slot did not take the data");
    protect_hold_a: assert property ( // R17
        frame_go && !wp_ok && cmd == rescmd_pkg::CMD_USER_WR && user_ok
        |=> nv_r[$past(addr)] == $past(nv_sel))
        else $error("protected store changed");
    restore_both_a: assert property ( // R10
        frame_go && cmd == rescmd_pkg::CMD_RESTORE_ALL
        |=> res_r[0] == $past(nv_ch1) && res_r[1] == $past(nv_ch2))
        else $error("restore of both channels failed");
    preset_load_a: assert property ( // R18
        preset_go |=> res_r[0] == $past(nv_ch1) && res_r[1] == $past(nv_ch2))
        else $error("preset strobe did not reload settings");
    wiper_read_a: assert property ( // R15
        frame_go && cmd == rescmd_pkg::CMD_WIPER_RD && ch_ok
        |=> echo_r == {$past(hdr), 6'h00, $past(sel_res)})
        else $error("wiper readback word is wrong");
    user_read_a: assert property ( // R14
        frame_go && cmd == rescmd_pkg::CMD_USER_RD
        |=> echo_r == {$past(hdr), $past(nv_sel)})
        else $error("user readback word is wrong");
    echo_word_a: assert property ( // R5
        frame_go && cmd != rescmd_pkg::CMD_USER_RD && cmd != rescmd_pkg::CMD_WIPER_RD
        |=> echo_r == $past(rx_word) ##1 $stable(echo_r))
        else $error("echo is not the previous frame");
    nop_idle_a: assert property ( // R16
        frame_go && cmd == rescmd_pkg::CMD_NOP
        |=> !read_mode && state_r == rescmd_pkg::ST_IDLE)
        else $error("no-operation did not return to idle");
    short_frame_a: assert property ( // R23
        frame_end && rx_count != rescmd_pkg::FRAME_LEN && !preset_go
        |=> $stable(res_r[0]) && $stable(res_r[1]) && $stable(echo_r))
        else $error("incomplete frame had an effect");
endmodule // dual_resistor_serial_command_core

/* File: serial_master_model.sv */
`timescale 1ns/1ps
module serial_master_model (
    output logic sclk,
    output logic cs_n,
    output logic serial_in,
    input wire logic serial_wire
);
    // No reset reaches the link, so one clean rising select at start-up puts the
    // slave's frame flags into a known state; the bit count is set by the first rising clock edge of a frame.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        serial_in = 1'b0;
        #5;
        cs_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The link clock holds its idle level between frames and moves only to the next frame's idle level before select falls; data idles at the inverse of
    // the last bit, so a slave that samples outside a frame sees a changing value.
    task automatic xfer(input logic [23:0] w, input int n, input logic cpol,
                        output logic [23:0] echo);
        echo = 24'h000000;
        #13;
        sclk = cpol;
        #80;
        cs_n = 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            serial_in = w[23 - i];
            #40;
            sclk = 1'b1;
            echo = {echo[22:0], serial_wire};
            #40;
        end
        sclk = cpol;
        #40;
        cs_n = 1'b1;
        serial_in = ~serial_in;
    endtask
endmodule // serial_master_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic mclk;
    logic rst;
    logic wp_n;
    logic preset_strobe_n;
    logic sclk;
    logic cs_n;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe;
    logic serial_wire;
    logic [1023:0] tap_sel_ch1;
    logic [1023:0] tap_sel_ch2;
    logic [1:0] bottom_terminal_switch;
    logic [9:0] resistor_setting_ch1;
    logic [9:0] resistor_setting_ch2;
    logic read_mode;
    logic [23:0] exp_echo;
    int fails;
    int n_compared;

    // The open-drain output only pulls low; the pull-up gives the high level.
    assign serial_wire = serial_out_oe ? serial_out : 1'b1;

    dual_resistor_serial_command_core u_dual_resistor_serial_command_core (
        .mclk(mclk),
        .rst(rst),
        .sclk(sclk),
        .cs_n(cs_n),
        .serial_in(serial_in),
        .wp_n(wp_n),
        .preset_strobe_n(preset_strobe_n),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe),
        .tap_sel_ch1(tap_sel_ch1),
        .tap_sel_ch2(tap_sel_ch2),
        .bottom_terminal_switch(bottom_terminal_switch),
        .resistor_setting_ch1(resistor_setting_ch1),
        .resistor_setting_ch2(resistor_setting_ch2),
        .read_mode(read_mode)
    );

    serial_master_model u_serial_master_model (
        .sclk(sclk),
        .cs_n(cs_n),
        .serial_in(serial_in),
        .serial_wire(serial_wire)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [1023:0] exp, input logic [1023:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: expected %0h, got %0h", $time, exp, got);
        end
    endtask

    task automatic frame(input logic [23:0] w, input int n = 24, input logic cpol = 1'b0);
        logic [23:0] got;
        u_serial_master_model.xfer(w, n, cpol, got);
        // A cut frame neither executes nor becomes the next echo.
        if (n == 24) begin
            chk(exp_echo, got);
            exp_echo = w;
        end
        repeat (8) @(posedge mclk);
    endtask

    task automatic chk_set(input logic [9:0] e1, input logic [9:0] e2);
        chk(e1, resistor_setting_ch1);
        chk(e2, resistor_setting_ch2);
        chk(1024'h1 << e1, tap_sel_ch1);
        chk(1024'h1 << e2, tap_sel_ch2);
        chk(2'h3, bottom_terminal_switch);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic sc_load();
        frame(24'hb00100);
        frame(24'hb10200);
        chk_set(10'h100, 10'h200);
        frame(24'hb003fe);
        frame(24'he0ffff);
        chk_set(10'h3ff, 10'h200);
    endtask

    task automatic sc_shift();
        frame(24'hb00200);
        frame(24'hc00000);
        frame(24'hb10005);
        frame(24'hc10000);
        chk_set(10'h3ff, 10'h00a);
        frame(24'hb10155, 24, 1'b1);
        chk_set(10'h3ff, 10'h155);
    endtask

    task automatic sc_save_restore();
        frame(24'hb00123);
        frame(24'h200000);
        frame(24'hb10077);
        frame(24'h210000);
        frame(24'hb00000);
        frame(24'hb10000);
        frame(24'h100000);
        chk_set(10'h123, 10'h000);
        chk(1'b1, read_mode);
        frame(24'h000000);
        chk(1'b0, read_mode);
        frame(24'h870000);
        chk_set(10'h123, 10'h077);
        frame(24'h000000);
    endtask

    task automatic sc_protect();
        @(posedge mclk) wp_n <= 1'b0;
        repeat (4) @(posedge mclk);
        frame(24'hb00055);
        frame(24'h200000);
        frame(24'hb00000);
        frame(24'h100000);
        chk_set(10'h123, 10'h077);
        frame(24'h32ffff);
        frame(24'h920000);
        exp_echo = 24'h920000;
        frame(24'h000000);
        @(posedge mclk) wp_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    task automatic sc_user_read();
        frame(24'h32aaaa);
        frame(24'h3e5555);
        frame(24'h920000);
        exp_echo = 24'h92aaaa;
        frame(24'h000000);
        frame(24'h9e0000);
        exp_echo = 24'h9e5555;
        frame(24'h000000);
        frame(24'ha00000);
        exp_echo = 24'ha00123;
        frame(24'h000000);
    endtask

    task automatic sc_abort();
        // A frame one bit short must leave settings and the echo word alone.
        frame(24'hb00200, 23);
        chk_set(10'h123, 10'h077);
        frame(24'hb00300);
        frame(24'hb10300);
        chk_set(10'h300, 10'h300);
    endtask

    task automatic sc_preset();
        @(posedge mclk) preset_strobe_n <= 1'b0;
        repeat (3) @(posedge mclk);
        preset_strobe_n <= 1'b1;
        repeat (8) @(posedge mclk);
        chk_set(10'h123, 10'h077);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        fails++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        preset_strobe_n = 1'b1;
        fails = 0;
        n_compared = 0;
        exp_echo = rescmd_pkg::ECHO_RST;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        chk_set(10'h000, 10'h000);
        chk(1'b0, read_mode);
        sc_load();
        sc_shift();
        sc_save_restore();
        sc_protect();
        sc_user_read();
        sc_abort();
        sc_preset();
        finish_test();
    end
endmodule // tb_top
